// >>> src/lad_ais_detect.sv
// alarm indication signal detector on received marks
`timescale 1ns/1ns
module lad_ais_detect (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // received bits
  input wire logic i_bit_en,
  input wire logic i_mark,
  // configuration
  input wire logic i_cdr_enable,
  input wire logic i_line_type_select,
  input wire logic i_criteria_standard_select,
  // status
  output logic o_alarm_signal_status
);
  logic [13:0] bit_cnt, next_bit_cnt;
  logic [3:0] zeros, next_zeros;
  logic prev_few, next_prev_few;
  logic prev_many, next_prev_many;
  logic next_ais;
  logic [13:0] blk_len;
  logic [3:0] z_lim;
  logic [3:0] zeros_in;
  logic few;

  // block length and zero limit per line type
  assign blk_len = i_line_type_select ? lad_pkg::AIS_BLK_T1 : lad_pkg::AIS_BLK_E1;
  assign z_lim = i_line_type_select ? lad_pkg::AIS_Z_T1 : lad_pkg::AIS_Z_E1;
  assign zeros_in = (!i_mark && zeros != lad_pkg::AIS_Z_SAT) ? zeros + 4'h1 : zeros;
  assign few = zeros_in < z_lim;

  // block counting and decision at block end
  always_comb begin
    next_bit_cnt = bit_cnt;
    next_zeros = zeros;
    next_prev_few = prev_few;
    next_prev_many = prev_many;
    next_ais = o_alarm_signal_status;
    if (!i_cdr_enable) begin
      next_bit_cnt = 14'h0000;
      next_zeros = 4'h0;
      next_prev_few = 1'b0;
      next_prev_many = 1'b0;
      next_ais = 1'b0;
    end else if (i_bit_en) begin
      if (bit_cnt == blk_len - 14'h0001) begin
        next_bit_cnt = 14'h0000;
        next_zeros = 4'h0;
        next_prev_few = few;
        next_prev_many = !few;
        if (i_line_type_select) begin
          next_ais = few;
        end else if (few && prev_few) begin
          next_ais = 1'b1;
        end else if (!few && (i_criteria_standard_select || prev_many)) begin
          next_ais = 1'b0;
        end
      end else begin
        next_bit_cnt = bit_cnt + 14'h0001;
        next_zeros = zeros_in;
      end
    end
  end

  // state registers
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bit_cnt <= 14'h0000;
      zeros <= 4'h0;
      prev_few <= 1'b0;
      prev_many <= 1'b0;
      o_alarm_signal_status <= 1'b0;
    end else begin
      bit_cnt <= next_bit_cnt;
      zeros <= next_zeros;
      prev_few <= next_prev_few;
      prev_many <= next_prev_many;
      o_alarm_signal_status <= next_ais;
    end
  end

  a_ais_cdr_off: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !i_cdr_enable |=> !o_alarm_signal_status) else $error("alarm status set with recovery disabled");
  a_ais_t1_block: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_cdr_enable && i_line_type_select && i_bit_en && bit_cnt == blk_len - 14'h0001)
    |=> o_alarm_signal_status == $past(few)) else $error("T1 alarm decision wrong at block end");
endmodule

// >>> src/lad_los_ais_top.sv
// loss-of-signal and alarm detector with wishbone registers and alarm insertion
//
// The Wishbone register port and the placing of the registers were decided locally.
`timescale 1ns/1ns
module lad_los_ais_top (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // line receiver pins and level comparators
  input wire logic i_line_rx_tip,
  input wire logic i_line_rx_ring,
  input wire logic i_rec_clk,
  input wire logic i_level_below_q,
  input wire logic i_level_above_p,
  // pulse interval strobe from clock recovery
  input wire logic i_bit_en,
  // transmit data from the transmit path
  input wire logic i_tx_pos,
  input wire logic i_tx_neg,
  // system side receive outputs
  output logic o_rx_data_pos,
  output logic o_rx_data_neg,
  output logic o_rx_clock_out,
  // line transmitter
  output logic o_line_tx_tip,
  output logic o_line_tx_ring,
  // status and threshold
  output logic o_signal_loss_out,
  output logic o_alarm_signal_status,
  output logic o_irq,
  output logic [5:0] o_threshold_db
);
  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [4:0] sync1, sync2;
  logic rx_tip, rx_ring, rec_clk, below_q, above_p, mark;

  // two flops on every asynchronous pin
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync1 <= 5'h00;
      sync2 <= 5'h00;
    end else begin
      sync1 <= {i_line_rx_tip, i_line_rx_ring, i_rec_clk, i_level_below_q, i_level_above_p};
      sync2 <= sync1;
    end
  end
  assign {rx_tip, rx_ring, rec_clk, below_q, above_p} = sync2;
  assign mark = rx_tip | rx_ring;

  // ---------------------------------------------------------------
  // register bus
  // ---------------------------------------------------------------
  logic [14:0] ctrl_q, next_ctrl;
  lad_pkg::lad_ctrl_s ctrl;
  logic evt, next_evt;
  logic next_irq;
  logic next_ack;
  logic [31:0] next_dat, rdata;
  logic wb_req, wr_ctrl, wr_evt;
  logic los, los_declare;
  logic [5:0] thr_db;

  assign ctrl = lad_pkg::lad_ctrl_s'(ctrl_q);
  assign wb_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  assign wr_ctrl = wb_req & i_wb_we & (i_wb_adr == lad_pkg::ADDR_CTRL);
  assign wr_evt = wb_req & i_wb_we & (i_wb_adr == lad_pkg::ADDR_EVT);

  // read mux, unmapped addresses read zero
  always_comb begin
    rdata = 32'h0000_0000;
    if (i_wb_adr == lad_pkg::ADDR_CTRL) begin
      rdata = {17'h00000, ctrl_q};
    end else if (i_wb_adr == lad_pkg::ADDR_STAT) begin
      rdata = {18'h00000, thr_db, 6'h00, o_alarm_signal_status, los};
    end else if (i_wb_adr == lad_pkg::ADDR_EVT) begin
      rdata = {31'h0000_0000, evt};
    end
  end

  // register writes, event clear by writing one, set wins
  always_comb begin
    next_ctrl = ctrl_q;
    if (wr_ctrl && i_wb_sel[0]) begin
      next_ctrl[7:0] = i_wb_dat[7:0];
    end
    if (wr_ctrl && i_wb_sel[1]) begin
      next_ctrl[14:8] = i_wb_dat[14:8];
    end
    next_evt = evt;
    if (wr_evt && i_wb_sel[0] && i_wb_dat[0]) begin
      next_evt = 1'b0;
    end
    if (los_declare) begin
      next_evt = 1'b1;
    end
    next_irq = evt & ~ctrl.irq_mask;
    next_ack = wb_req;
    next_dat = wb_req ? rdata : 32'h0000_0000;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_q <= lad_pkg::CTRL_RST;
      evt <= 1'b0;
      o_irq <= 1'b0;
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end else begin
      ctrl_q <= next_ctrl;
      evt <= next_evt;
      o_irq <= next_irq;
      o_wb_ack <= next_ack;
      o_wb_dat <= next_dat;
    end
  end

  // ---------------------------------------------------------------
  // loss-of-signal declare and clear
  // ---------------------------------------------------------------
  lad_pkg::lad_state_e state, next_state;
  logic [11:0] decl_cnt, next_decl, decl_lim;
  logic [7:0] win_cnt, next_win, marks, next_marks, m_lim, d_lim, marks_in;
  logic [6:0] zrun, next_zrun, z_lim, zrun_in;

  // limits picked by line type and criteria, same for long and short haul
  always_comb begin
    if (ctrl.line_type_select) begin
      decl_lim = ctrl.criteria_standard_select ? lad_pkg::DECL_T1_B : lad_pkg::DECL_T1_A;
      m_lim = lad_pkg::CLR_M_T1;
      d_lim = lad_pkg::DENS_T1;
      z_lim = lad_pkg::ZRUN_T1;
    end else begin
      decl_lim = ctrl.criteria_standard_select ? lad_pkg::DECL_E1_B : lad_pkg::DECL_E1_A;
      m_lim = lad_pkg::CLR_M_E1;
      d_lim = lad_pkg::DENS_E1;
      z_lim = lad_pkg::ZRUN_E1;
    end
  end
  assign marks_in = marks + {7'h00, mark};
  assign zrun_in = mark ? 7'h00 : zrun + 7'h01;

  // state machine, advances on pulse interval strobes; loopback never gates it
  always_comb begin
    next_state = state;
    next_decl = decl_cnt;
    next_win = win_cnt;
    next_marks = marks;
    next_zrun = zrun;
    los_declare = 1'b0;
    if (i_bit_en) begin
      unique case (state)
        lad_pkg::ST_OK: begin
          if (!below_q) begin
            next_decl = 12'h000;
          end else if (decl_cnt == decl_lim - 12'h001) begin
            next_state = lad_pkg::ST_LOST;
            next_decl = 12'h000;
            los_declare = 1'b1;
          end else begin
            next_decl = decl_cnt + 12'h001;
          end
        end
        lad_pkg::ST_LOST: begin
          if (mark && above_p) begin
            next_state = lad_pkg::ST_CLEARING;
            next_win = 8'h01;
            next_marks = 8'h01;
            next_zrun = 7'h00;
          end
        end
        lad_pkg::ST_CLEARING: begin
          if (mark && !above_p) begin
            next_state = lad_pkg::ST_LOST;
          end else if (zrun_in >= z_lim) begin
            next_state = lad_pkg::ST_LOST;
          end else if (win_cnt == m_lim - 8'h01) begin
            next_state = (marks_in >= d_lim) ? lad_pkg::ST_OK : lad_pkg::ST_LOST;
          end else begin
            next_win = win_cnt + 8'h01;
            next_marks = marks_in;
            next_zrun = zrun_in;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= lad_pkg::ST_OK;
      decl_cnt <= 12'h000;
      win_cnt <= 8'h00;
      marks <= 8'h00;
      zrun <= 7'h00;
    end else begin
      state <= next_state;
      decl_cnt <= next_decl;
      win_cnt <= next_win;
      marks <= next_marks;
      zrun <= next_zrun;
    end
  end
  assign los = (state != lad_pkg::ST_OK);

  // long haul threshold magnitude: 4 dB plus 2 dB per code, saturating
  assign thr_db = (ctrl.thr_code >= lad_pkg::THR_SAT_CODE) ? lad_pkg::THR_SAT_DB
                : {ctrl.thr_code, 1'b0} + lad_pkg::THR_BASE_DB;

  // ---------------------------------------------------------------
  // master clock patterns and output muxing
  // ---------------------------------------------------------------
  logic [2:0] div_cnt, next_div;
  logic mclk, next_mclk, alt, next_alt;
  logic sys_ones, line_ones, tick;
  logic next_rx_pos, next_rx_neg, next_rx_clk, next_tx_tip, next_tx_ring;

  assign tick = (div_cnt == lad_pkg::MCLK_HALF - 3'h1);
  assign sys_ones = los & ctrl.sys_alarm_ones_enable;
  assign line_ones = los & ctrl.line_alarm_ones_enable;

  // master-derived clock and alternating mark phase, then output selection
  always_comb begin
    next_div = tick ? 3'h0 : div_cnt + 3'h1;
    next_mclk = tick ? ~mclk : mclk;
    next_alt = (tick && !mclk) ? ~alt : alt;
    next_rx_pos = sys_ones ? alt : rx_tip;
    next_rx_neg = sys_ones ? ~alt : rx_ring;
    next_rx_clk = sys_ones ? mclk : rec_clk;
    next_tx_tip = line_ones ? alt : i_tx_pos;
    next_tx_ring = line_ones ? ~alt : i_tx_neg;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_cnt <= 3'h0;
      mclk <= 1'b0;
      alt <= 1'b0;
      o_rx_data_pos <= 1'b0;
      o_rx_data_neg <= 1'b0;
      o_rx_clock_out <= 1'b0;
      o_line_tx_tip <= 1'b0;
      o_line_tx_ring <= 1'b0;
      o_signal_loss_out <= 1'b0;
      o_threshold_db <= 6'h00;
    end else begin
      div_cnt <= next_div;
      mclk <= next_mclk;
      alt <= next_alt;
      o_rx_data_pos <= next_rx_pos;
      o_rx_data_neg <= next_rx_neg;
      o_rx_clock_out <= next_rx_clk;
      o_line_tx_tip <= next_tx_tip;
      o_line_tx_ring <= next_tx_ring;
      o_signal_loss_out <= los;
      o_threshold_db <= thr_db;
    end
  end

  // alarm indication detector
  lad_ais_detect u_ais (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_bit_en(i_bit_en),
    .i_mark(mark),
    .i_cdr_enable(ctrl.cdr_enable),
    .i_line_type_select(ctrl.line_type_select),
    .i_criteria_standard_select(ctrl.criteria_standard_select),
    .o_alarm_signal_status(o_alarm_signal_status)
  );

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_los_declare_out: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    los_declare |=> (state == lad_pkg::ST_LOST) ##1 o_signal_loss_out) else $error("loss not declared");
  a_decl_break: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (state == lad_pkg::ST_OK && i_bit_en && !below_q) |=> decl_cnt == 12'h000) else $error("declare count kept");
  a_clear_start: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (state == lad_pkg::ST_LOST && i_bit_en && mark && above_p) |=> state == lad_pkg::ST_CLEARING)
    else $error("clear window did not start on pulse");
  a_zero_abort: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (state == lad_pkg::ST_CLEARING && i_bit_en && !mark && zrun_in >= z_lim) |=> state == lad_pkg::ST_LOST)
    else $error("zero run did not abort clear");
  a_rx_follow: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !sys_ones |=> (o_rx_data_pos == $past(rx_tip)) && (o_rx_clock_out == $past(rec_clk)))
    else $error("receive outputs do not follow line");
  a_sys_ones_data: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    sys_ones |=> (o_rx_data_pos ^ o_rx_data_neg) && (o_rx_clock_out == $past(mclk)))
    else $error("system all-ones insertion wrong");
  a_tx_ones: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    line_ones |=> (o_line_tx_tip == $past(alt)) && (o_line_tx_tip ^ o_line_tx_ring))
    else $error("line all-ones insertion wrong");
  a_irq_mask: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (los_declare && !ctrl.irq_mask && !next_ctrl[6]) |=> ##1 o_irq) else $error("unmasked interrupt missing");
  a_thr_sat: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (ctrl.thr_code >= lad_pkg::THR_SAT_CODE) |=> o_threshold_db == lad_pkg::THR_SAT_DB)
    else $error("threshold not saturated");
  a_ack_pulse: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_wb_ack |=> !o_wb_ack) else $error("ack longer than one cycle");
endmodule

// >>> src/lad_pkg.sv
// constants, types and register map of the loss-of-signal and alarm detector
// How it works
// - line type and criteria bits pick criteria
// - loss without insertion: receive outputs follow line
// - loss with system insertion: all-ones receive data
// - system insertion takes receive clock from master
// - line insertion sends all-ones on transmitter
// - loss indication works in every loopback
// - T1 criteria A declares after 175 intervals
// - T1 criteria B declares after 1544 intervals
// - E1 criteria A declares after 32 intervals
// - E1 criteria B declares after 2048 intervals
// - T1 clear: 128 intervals, density, under 100 zeros
// - E1 clear: 32 intervals, density, under 16 zeros
// - long haul uses same declare interval counts
// - long haul clear uses same windows, higher level
// - alarm detection only with recovery enabled, status
// - one T1 criterion, E1 criterion by select
// - E1 two blocks of 512 bits, zeros under 3
// - T1 one block of 8192 bits, zeros under 9
// - loss output follows state, interrupt unless masked
// - clear window starts at a received pulse
package lad_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_EVT = 8'h08;
  localparam logic [14:0] CTRL_RST = 15'h5420;

  // control register layout, low bit is bit 0 of the word
  typedef struct packed {
    logic [4:0] thr_code;
    logic [2:0] loopback;
    logic irq_mask;
    logic cdr_enable;
    logic long_haul;
    logic line_alarm_ones_enable;
    logic sys_alarm_ones_enable;
    logic criteria_standard_select;
    logic line_type_select;
  } lad_ctrl_s;

  // ---------------------------------------------------------------
  // loss-of-signal counts
  // ---------------------------------------------------------------
  localparam logic [11:0] DECL_T1_A = 12'h0AF;
  localparam logic [11:0] DECL_T1_B = 12'h608;
  localparam logic [11:0] DECL_E1_A = 12'h020;
  localparam logic [11:0] DECL_E1_B = 12'h800;
  localparam logic [7:0] CLR_M_T1 = 8'h80;
  localparam logic [7:0] CLR_M_E1 = 8'h20;
  localparam logic [7:0] DENS_T1 = 8'h10;
  localparam logic [7:0] DENS_E1 = 8'h04;
  localparam logic [6:0] ZRUN_T1 = 7'h64;
  localparam logic [6:0] ZRUN_E1 = 7'h10;

  // ---------------------------------------------------------------
  // long haul threshold code mapping, magnitude in dB below nominal
  // ---------------------------------------------------------------
  localparam logic [5:0] THR_BASE_DB = 6'h04;
  localparam logic [4:0] THR_SAT_CODE = 5'h16;
  localparam logic [5:0] THR_SAT_DB = 6'h30;

  // ---------------------------------------------------------------
  // alarm indication blocks
  // ---------------------------------------------------------------
  localparam logic [13:0] AIS_BLK_T1 = 14'h2000;
  localparam logic [13:0] AIS_BLK_E1 = 14'h0200;
  localparam logic [3:0] AIS_Z_T1 = 4'h9;
  localparam logic [3:0] AIS_Z_E1 = 4'h3;
  localparam logic [3:0] AIS_Z_SAT = 4'hF;

  // master clock half period for substitute patterns, in i_clk cycles
  localparam logic [2:0] MCLK_HALF = 3'h5;

  typedef enum logic [1:0] {
    ST_OK = 2'b00,
    ST_LOST = 2'b01,
    ST_CLEARING = 2'b10
  } lad_state_e;
endpackage

// >>> verif/lad_line_model.sv
// line receiver model: marks, level comparators, recovered clock and interval strobe
`timescale 1ns/1ns
module lad_line_model (
  // clock
  input wire logic i_clk,
  // receiver pins and analog comparators
  output logic o_tip,
  output logic o_ring,
  output logic o_rec_clk,
  output logic o_below_q,
  output logic o_above_p,
  // interval strobe
  output logic o_bit_en
);
  logic pol = 1'b0;

  initial begin
    o_tip = 1'b0;
    o_ring = 1'b0;
    o_rec_clk = 1'b0;
    o_below_q = 1'b0;
    o_above_p = 1'b0;
    o_bit_en = 1'b0;
  end

  // ---------------------------------------------------------------
  // one pulse interval
  // ---------------------------------------------------------------
  // pins settle three edges before the strobe so the two sync flops see them
  task automatic pulse(input logic mark, input logic below, input logic above);
    @(posedge i_clk);
    o_tip <= mark & pol; // marks alternate between rails
    o_ring <= mark & ~pol;
    if (mark) begin
      pol <= ~pol;
    end
    o_below_q <= below;
    o_above_p <= above;
    o_rec_clk <= 1'b1;
    repeat (3) @(posedge i_clk);
    o_bit_en <= 1'b1;
    o_rec_clk <= 1'b0;
    @(posedge i_clk);
    o_bit_en <= 1'b0;
  endtask
endmodule

// >>> verif/testbench.sv
// self-checking bench for the loss-of-signal and alarm detector
`timescale 1ns/1ns
module testbench;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic tx_pos = 1'b0;
  logic tx_neg = 1'b0;
  logic tx_q_pos = 1'b0;
  logic tx_q_neg = 1'b0;
  logic tip, ring, rclk, below, above, bit_en;
  logic [31:0] o_wb_dat;
  logic o_wb_ack, rx_pos, rx_neg, rx_clk, ltx_tip, ltx_ring, loss, alarm, irq;
  logic [5:0] thr_db;
  int err_count = 0;
  int num_checks = 0;
  int seed = 32'h4BD9;
  int cycles = 0;
  int exp_los = 0;

  lad_line_model line (.i_clk(i_clk), .o_tip(tip), .o_ring(ring), .o_rec_clk(rclk), .o_below_q(below),
    .o_above_p(above), .o_bit_en(bit_en));

  lad_los_ais_top dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
    .i_line_rx_tip(tip), .i_line_rx_ring(ring), .i_rec_clk(rclk), .i_level_below_q(below),
    .i_level_above_p(above), .i_bit_en(bit_en), .i_tx_pos(tx_pos), .i_tx_neg(tx_neg),
    .o_rx_data_pos(rx_pos), .o_rx_data_neg(rx_neg), .o_rx_clock_out(rx_clk), .o_line_tx_tip(ltx_tip),
    .o_line_tx_ring(ltx_ring), .o_signal_loss_out(loss), .o_alarm_signal_status(alarm), .o_irq(irq),
    .o_threshold_db(thr_db));

  // ---------------------------------------------------------------
  // clock, random transmit rails, hang guard
  // ---------------------------------------------------------------
  always #50 i_clk = ~i_clk;

  // tx_q mirrors the one-flop transmit pass-through
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    tx_pos <= $random(seed);
    tx_neg <= $random(seed);
    tx_q_pos <= tx_pos;
    tx_q_neg <= tx_neg;
    if (cycles == 95000) begin
      err_count = err_count + 1;
      final_report();
    end
  end

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  // classic wishbone cycle: hold until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge i_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_wb_ack !== 1'b1 && n < 20);
    q = o_wb_dat;
    chk("wishbone ack", 32'h1, {31'h0, o_wb_ack});
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic settle();
    repeat (3) @(posedge i_clk);
    @(negedge i_clk);
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [31:0] q;
    logic [14:0] ctrl;
    logic [4:0] thr;
    logic t1, b, prev;
    int n, mm, tog, bad;
    repeat (10) @(posedge i_clk);
    i_rst_n <= 1'b1;
    // outputs leave their reset values at the first edge after release
    @(posedge i_clk);
    @(negedge i_clk);
    chk("threshold_db", 32'd46, {26'h0, thr_db});
    wb(1'b0, lad_pkg::ADDR_CTRL, 32'h0, q);
    chk("ctrl reset", 32'h5420, q);
    wb(1'b1, lad_pkg::ADDR_STAT, 32'hFFFF_FFFF, q);
    wb(1'b0, lad_pkg::ADDR_STAT, 32'h0, q);
    chk("status", {18'h0, 6'h2E, 8'h00}, q);
    wb(1'b0, 8'h0C, 32'h0, q);
    chk("unmapped read", 32'h0, q);
    // threshold code to dB, short haul so no range applies
    for (int c = 0; c < 32; c++) begin
      wb(1'b1, lad_pkg::ADDR_CTRL, {17'h0, c[4:0], 10'h020}, q);
      settle();
      chk("threshold_db", (c < 22) ? 4 + 2 * c : 48, {26'h0, thr_db});
    end
    // four criteria sets, loopback always nonzero, long haul on criteria B
    for (int m = 0; m < 4; m++) begin
      t1 = m[1];
      b = m[0];
      thr = (m == 0) ? 5'h08 : (m == 1) ? 5'h05 : (m == 2) ? 5'h10 : 5'h08;
      // interrupt masked on criteria B passes so both mask settings are seen
      ctrl = {thr, m[2:0] + 3'h1, b, 1'b1, b, 2'b00, b, t1};
      n = t1 ? (b ? 1544 : 175) : (b ? 2048 : 32);
      mm = t1 ? 128 : 32;
      wb(1'b1, lad_pkg::ADDR_CTRL, {17'h0, ctrl}, q);
      repeat (5) line.pulse($random(seed), 1'b1, 1'b0);
      line.pulse(1'b1, 1'b0, 1'b1);
      repeat (n - 1) line.pulse($random(seed), 1'b1, 1'b0);
      settle();
      chk("loss before count", exp_los, {31'h0, loss});
      line.pulse($random(seed), 1'b1, 1'b0);
      settle();
      exp_los = 1;
      chk("loss declared", exp_los, {31'h0, loss});
      wb(1'b0, lad_pkg::ADDR_EVT, 32'h0, q);
      chk("loss event", 32'h1, q & 32'h1);
      chk("irq", {31'h0, ~b}, {31'h0, irq});
      wb(1'b1, lad_pkg::ADDR_EVT, 32'h1, q);
      settle();
      chk("irq cleared", 32'h0, {31'h0, irq});
      line.pulse(1'b1, 1'b0, 1'b0);
      settle();
      chk("rx rails", {30'h0, tip, ring}, {30'h0, rx_pos, rx_neg});
      chk("rx clock", {31'h0, rclk}, {31'h0, rx_clk});
      chk("tx rails", {30'h0, tx_q_pos, tx_q_neg}, {30'h0, ltx_tip, ltx_ring});
      chk("loss held", exp_los, {31'h0, loss});
      wb(1'b1, lad_pkg::ADDR_CTRL, {17'h0, ctrl | 15'h000C}, q);
      settle();
      tog = 0;
      bad = 0;
      prev = rx_clk;
      for (int i = 0; i < 20; i++) begin
        @(negedge i_clk);
        if (rx_clk !== prev) tog++;
        prev = rx_clk;
        if (rx_pos === rx_neg) bad++;
        if (ltx_tip === ltx_ring) bad++;
      end
      chk("master clock toggles", 32'd4, tog);
      chk("all ones errors", 32'd0, bad);
      wb(1'b1, lad_pkg::ADDR_CTRL, {17'h0, ctrl}, q);
      repeat (mm - 1) line.pulse(1'b1, 1'b0, 1'b1);
      settle();
      chk("loss in window", exp_los, {31'h0, loss});
      line.pulse(1'b1, 1'b0, 1'b1);
      settle();
      exp_los = 0;
      chk("loss cleared", exp_los, {31'h0, loss});
    end
    // alarm detection, E1 criteria A then B, then T1
    wb(1'b1, lad_pkg::ADDR_CTRL, 32'h5400, q);
    settle();
    chk("alarm without recovery", 32'h0, {31'h0, alarm});
    wb(1'b1, lad_pkg::ADDR_CTRL, 32'h5420, q);
    repeat (1024) line.pulse(1'b1, 1'b0, 1'b1);
    settle();
    chk("alarm e1", 32'h1, {31'h0, alarm});
    wb(1'b1, lad_pkg::ADDR_CTRL, 32'h5422, q);
    repeat (3) line.pulse(1'b0, 1'b0, 1'b1);
    repeat (509) line.pulse(1'b1, 1'b0, 1'b1);
    settle();
    chk("alarm e1 cleared", 32'h0, {31'h0, alarm});
    wb(1'b1, lad_pkg::ADDR_CTRL, 32'h5401, q);
    wb(1'b1, lad_pkg::ADDR_CTRL, 32'h5421, q);
    repeat (8192) line.pulse(1'b1, 1'b0, 1'b1);
    settle();
    chk("alarm t1", 32'h1, {31'h0, alarm});
    // a set alarm must drop once recovery is switched off
    wb(1'b1, lad_pkg::ADDR_CTRL, 32'h5401, q);
    settle();
    chk("alarm dropped without recovery", 32'h0, {31'h0, alarm});
    final_report();
  end
endmodule
